/* rtl/wdt_pkg.sv */
// Constants and types for the watchdog, sleep and wake-up block
`default_nettype none

package wdt_pkg;

	// ==========================================================
	// Clock and time
	localparam int unsigned CLK_PERIOD_NS       = 40;
	localparam int unsigned WDT_BASE_TIMEOUT_NS = 18_000_000;
	// Nominal period, exact at 25 MHz (450000 cycles)
	localparam int unsigned WDT_BASE_CYCLES     = WDT_BASE_TIMEOUT_NS / CLK_PERIOD_NS;
	// Watchdog counter steps per base period
	localparam int unsigned WDT_COUNT_STEPS     = 256;

	// ==========================================================
	// Register port
	localparam int unsigned ADDR_WIDTH  = 2;
	localparam int unsigned DATA_WIDTH  = 8;
	localparam logic [1:0]  ADDR_OPTION = 2'h0;
	localparam logic [1:0]  ADDR_STATUS = 2'h1;
	localparam logic [1:0]  ADDR_EVENT  = 2'h2;
	localparam logic [1:0]  ADDR_MASK   = 2'h3;

	// ==========================================================
	// Fields and reset values
	localparam int unsigned PSA_BIT       = 3;
	localparam int unsigned PS_MSB        = 2;
	localparam int unsigned TO_BIT        = 4;
	localparam int unsigned PD_BIT        = 3;
	localparam logic [7:0]  OPTION_RESET  = 8'h3F;
	localparam logic [7:0]  OPTION_MASK   = 8'h3F;

	// Event bits
	localparam int unsigned EV_WIDTH      = 3;
	localparam int unsigned EV_WDT_BIT    = 0;
	localparam int unsigned EV_WAKE_BIT   = 1;
	localparam int unsigned EV_MASTER_CLEAR_PIN_N_BIT   = 2;
	localparam logic [2:0]  EV_RESET      = 3'h0;

	// Pins and synchronisers
	localparam int unsigned PIN_WIDTH     = 8;
	localparam logic [7:0]  PIN_OE_N_RESET = 8'hFF;
	localparam int unsigned SYNC_CHANNELS = 2;
	localparam int unsigned SYNC_MASTER_CLEAR_PIN_N     = 0;
	localparam int unsigned SYNC_FUSE     = 1;
	// Clear pin idle high, fuse low until seen
	localparam logic [5:0]  SYNC_RESET    = 6'h07;

	typedef enum logic {
		PS_RUN,
		PS_SLEEP
	} power_state_t;

endpackage

`default_nettype wire

/* rtl/watchdog_sleep_wakeup.sv */
// Watchdog timer with shared divider, power-down entry and wake-up
//
// Overview of operation
// - Watchdog ticks from own always-running oscillator enable
// - Time-out raises full device reset, awake or asleep
// - Time-out reset clears timeout flag (status bit 4)
// - Fuse at zero keeps watchdog disabled
// - One 8-bit divider, timer or watchdog
// - Option low nibble selects assignment and ratio
// - Base 18 ms, up to 1:128 postscale
// - Clear instruction resets count and assigned divider
// - Sleep instruction resets count and assigned divider
// - Sleep entry: flags set/clear, oscillator driver off
// - Pins keep pre-sleep drive state while asleep
// - Watchdog reset never drives master clear pin
// - Wake only by master clear or time-out
// - Powerdown flag set at power-up, cleared by sleep
// - Watchdog count cleared on every wake-up
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`default_nettype none

module watchdog_sleep_wakeup #(
	parameter int unsigned BASE_CYCLES = wdt_pkg::WDT_BASE_CYCLES
) (
	input  wire logic                           mclk_i,
	input  wire logic                           srst_i,
	input  wire logic [wdt_pkg::ADDR_WIDTH-1:0] reg_addr_i,
	input  wire logic [wdt_pkg::DATA_WIDTH-1:0] reg_wdata_i,
	input  wire logic                           reg_we_i,
	input  wire logic                           reg_re_i,
	output logic      [wdt_pkg::DATA_WIDTH-1:0] reg_rdata_o,
	input  wire logic                           watchdog_fuse_enable_i,
	input  wire logic                           master_clear_pin_n_i,
	output logic                                master_clear_pin_n_o,
	output logic                                master_clear_pin_n_oe_n_o,
	input  wire logic                           watchdog_clear_instr_i,
	input  wire logic                           sleep_instr_i,
	input  wire logic                           timer_event_i,
	output logic                                timer_tick_o,
	input  wire logic [wdt_pkg::PIN_WIDTH-1:0]  core_pin_out_i,
	input  wire logic [wdt_pkg::PIN_WIDTH-1:0]  core_pin_oe_n_i,
	output logic      [wdt_pkg::PIN_WIDTH-1:0]  pin_out_o,
	output logic      [wdt_pkg::PIN_WIDTH-1:0]  pin_oe_n_o,
	output logic                                osc_drive_en_o,
	output logic                                sleeping_o,
	output logic                                device_reset_o,
	output logic                                irq_o
);
	import wdt_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		power_state_t              pstate;
		logic [SYNC_CHANNELS-1:0][2:0] sync;
		logic                      master_clear_pin_n_pin_lvl;
		logic                      fuse_on;
		logic [11:0]               rc_div;
		logic [7:0]                wdt_count;
		logic [7:0]                prescaler;
		logic [7:0]                option;
		logic                      timeout_flag_n;
		logic                      powerdown_flag_n;
		logic [EV_WIDTH-1:0]       events;
		logic [EV_WIDTH-1:0]       mask;
		logic [7:0]                rdata;
		logic                      dev_reset;
		logic                      timer_tick;
		logic [PIN_WIDTH-1:0]      pin_out;
		logic [PIN_WIDTH-1:0]      pin_oe_n;
	} state_t;

	localparam state_t STATE_RESET = '{
		pstate:           PS_RUN,
		sync:             SYNC_RESET,
		master_clear_pin_n_pin_lvl:     1'b1,
		option:           OPTION_RESET,
		timeout_flag_n:   1'b1,
		powerdown_flag_n: 1'b1,
		events:           EV_RESET,
		mask:             EV_RESET,
		pin_oe_n:         PIN_OE_N_RESET,
		default:          '0
	};

	// Last value of the oscillator divider; 12 bits hold 1756
	localparam logic [11:0] RC_TICK_LAST = 12'(BASE_CYCLES / WDT_COUNT_STEPS - 1);

	state_t r;
	state_t next_r;

	logic [SYNC_CHANNELS-1:0] pin_raw;
	logic                     rc_tick;
	logic                     wdt_overflow;
	logic                     timeout;
	logic                     master_clear_pin_n_now;
	logic                     master_clear_pin_n_rise;
	logic                     core_live;
	logic                     prescaler_assign_sel;
	logic [2:0]               ratio;
	logic [7:0]               post_last;
	logic [7:0]               pre_last;
	logic [EV_WIDTH-1:0]      ev_set;
	logic [EV_WIDTH-1:0]      ev_clr;

	// Raw asynchronous inputs into the synchroniser chains
	assign pin_raw[SYNC_MASTER_CLEAR_PIN_N] = master_clear_pin_n_i;
	assign pin_raw[SYNC_FUSE] = watchdog_fuse_enable_i;

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_r            = r;
		next_r.rdata      = '0;
		next_r.timer_tick = 1'b0;
		next_r.dev_reset  = 1'b0;
		timeout           = 1'b0;
		ev_set            = '0;
		ev_clr            = '0;

		// Three-stage chains; a level counts once stages two and three agree
		for (int i = 0; i < SYNC_CHANNELS; i++) begin
			next_r.sync[i] = {r.sync[i][1:0], pin_raw[i]};
		end
		if (r.sync[SYNC_MASTER_CLEAR_PIN_N][1] == r.sync[SYNC_MASTER_CLEAR_PIN_N][2]) begin
			next_r.master_clear_pin_n_pin_lvl = r.sync[SYNC_MASTER_CLEAR_PIN_N][2];
		end
		if (r.sync[SYNC_FUSE][1] == r.sync[SYNC_FUSE][2]) begin
			next_r.fuse_on = r.sync[SYNC_FUSE][2];
		end
		master_clear_pin_n_now  = !next_r.master_clear_pin_n_pin_lvl;
		master_clear_pin_n_rise = master_clear_pin_n_now && r.master_clear_pin_n_pin_lvl;
		// Core executes only while awake and out of reset
		core_live = (r.pstate == PS_RUN) && r.master_clear_pin_n_pin_lvl;

		prescaler_assign_sel   = r.option[PSA_BIT];
		ratio = r.option[PS_MSB:0];

		// oscillator stand-in, never gated by sleep
		rc_tick = (r.rc_div == RC_TICK_LAST);
		if (rc_tick) begin
			next_r.rc_div = '0;
		end else begin
			next_r.rc_div = r.rc_div + 12'h001;
		end

		// 256 ticks make the base period
		wdt_overflow = 1'b0;
		// fuse off stops the count entirely
		if (r.fuse_on && rc_tick) begin
			next_r.wdt_count = r.wdt_count + 8'h01;
			wdt_overflow     = (r.wdt_count == 8'hFF);
		end

		post_last = 8'((16'h0001 << ratio) - 16'h0001);
		// Timer prescale keeps its 1:2 to 1:256 range
		pre_last  = 8'((16'h0002 << ratio) - 16'h0001);

		// shared divider serves one user only
		if (prescaler_assign_sel) begin
			if (wdt_overflow) begin
				if (r.prescaler == post_last) begin
					next_r.prescaler = '0;
					timeout          = 1'b1;
				end else begin
					next_r.prescaler = r.prescaler + 8'h01;
				end
			end
		end else begin
			timeout = wdt_overflow;
			if (timer_event_i && core_live) begin
				if (r.prescaler == pre_last) begin
					next_r.prescaler  = '0;
					next_r.timer_tick = 1'b1;
				end else begin
					next_r.prescaler = r.prescaler + 8'h01;
				end
			end
		end

		// clear in the overflow cycle still prevents the reset
		if (watchdog_clear_instr_i && core_live) begin
			timeout                 = 1'b0;
			next_r.wdt_count        = '0;
			next_r.timeout_flag_n   = 1'b1;
			next_r.powerdown_flag_n = 1'b1;
			if (prescaler_assign_sel) begin
				next_r.prescaler = '0;
			end
		end

		// Power-down entry
		if (sleep_instr_i && core_live && !timeout) begin
			// full period before a time-out wake
			next_r.wdt_count = '0;
			if (prescaler_assign_sel) begin
				next_r.prescaler = '0;
			end
			// flags, and the oscillator driver goes off
			next_r.timeout_flag_n = 1'b1;
			// only sleep clears the powerdown flag
			next_r.powerdown_flag_n = 1'b0;
			next_r.pstate           = PS_SLEEP;
		end

		// pins follow the core only while awake
		if (r.pstate == PS_RUN) begin
			next_r.pin_out  = core_pin_out_i;
			next_r.pin_oe_n = core_pin_oe_n_i;
		end

		// Register writes; option is frozen while the core is held
		if (reg_we_i && reg_addr_i == ADDR_OPTION && r.master_clear_pin_n_pin_lvl) begin
			next_r.option = reg_wdata_i & OPTION_MASK;
		end
		if (reg_we_i && reg_addr_i == ADDR_MASK) begin
			next_r.mask = reg_wdata_i[EV_WIDTH-1:0];
		end
		if (reg_we_i && reg_addr_i == ADDR_EVENT) begin
			ev_clr = reg_wdata_i[EV_WIDTH-1:0];
		end

		// time-out resets the device in either power state
		if (timeout) begin
			next_r.dev_reset = 1'b1;
			// time-out marks itself in the status flag
			next_r.timeout_flag_n = 1'b0;
			ev_set[EV_WDT_BIT]    = 1'b1;
		end

		// Master clear holds the device in reset while low
		if (master_clear_pin_n_now) begin
			next_r.dev_reset = 1'b1;
		end
		if (master_clear_pin_n_rise) begin
			ev_set[EV_MASTER_CLEAR_PIN_N_BIT] = 1'b1;
		end

		// Any device reset restores option, count and divider
		if (next_r.dev_reset) begin
			next_r.option    = OPTION_RESET;
			next_r.wdt_count = '0;
			next_r.prescaler = '0;
		end

		// only a device reset leaves power-down
		if (r.pstate == PS_SLEEP && next_r.dev_reset) begin
			next_r.pstate       = PS_RUN;
			ev_set[EV_WAKE_BIT] = 1'b1;
			next_r.wdt_count = '0;
		end

		// Sticky events: a set in the clearing cycle wins
		next_r.events = (r.events & ~ev_clr) | ev_set;

		// Read data valid the cycle after the strobe only
		if (reg_re_i) begin
			case (reg_addr_i)
				ADDR_OPTION: begin
					next_r.rdata = r.option;
				end
				ADDR_STATUS: begin
					next_r.rdata[TO_BIT] = r.timeout_flag_n;
					next_r.rdata[PD_BIT] = r.powerdown_flag_n;
				end
				ADDR_EVENT: begin
					next_r.rdata[EV_WIDTH-1:0] = r.events;
				end
				ADDR_MASK: begin
					next_r.rdata[EV_WIDTH-1:0] = r.mask;
				end
				default: begin
					next_r.rdata = '0;
				end
			endcase
		end
	end

	// ==========================================================
	// State register; power-on reset also sets both flags
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			r <= STATE_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata_o    = r.rdata;
	assign timer_tick_o   = r.timer_tick;
	assign pin_out_o      = r.pin_out;
	assign pin_oe_n_o     = r.pin_oe_n;
	assign sleeping_o     = (r.pstate == PS_SLEEP);
	assign device_reset_o = r.dev_reset;
	// Main oscillator driver runs only while awake
	assign osc_drive_en_o = (r.pstate == PS_RUN);
	// Level interrupt from unmasked sticky events
	assign irq_o          = |(r.events & r.mask);

	// clear pin stays an input under any reset
	assign master_clear_pin_n_o      = 1'b1;
	assign master_clear_pin_n_oe_n_o = 1'b1;

endmodule

`default_nettype wire

/* tb/wdt_sva.sv */
// Port-level checks for the watchdog, sleep and wake-up block
`default_nettype none
module wdt_sva
	import wdt_pkg::*;
#(
	parameter int unsigned BASE_CYCLES = WDT_BASE_CYCLES
) (
	input wire logic                 mclk_i,
	input wire logic                 srst_i,
	input wire logic                 watchdog_fuse_enable_i,
	input wire logic                 master_clear_pin_n_i,
	input wire logic                 master_clear_pin_n_oe_n_o,
	input wire logic                 watchdog_clear_instr_i,
	input wire logic                 sleep_instr_i,
	input wire logic [PIN_WIDTH-1:0] pin_out_o,
	input wire logic [PIN_WIDTH-1:0] pin_oe_n_o,
	input wire logic                 osc_drive_en_o,
	input wire logic                 sleeping_o,
	input wire logic                 device_reset_o
);
	// Earliest time-out after a restart; slack covers the tick phase
	localparam int unsigned MIN_TO = BASE_CYCLES - BASE_CYCLES / 256 - 2;
	logic [15:0] since;
	logic [15:0] foff;
	logic [15:0] mhi;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// Run lengths saturate so long idle spells never wrap
	always_ff @(posedge mclk_i) begin
		since <= (srst_i || watchdog_clear_instr_i || sleep_instr_i || device_reset_o)
			? 16'h0 : since + {15'h0, ~&since};
		foff <= watchdog_fuse_enable_i ? 16'h0 : foff + {15'h0, ~&foff};
		mhi <= (master_clear_pin_n_i && !srst_i) ? mhi + {15'h0, ~&mhi} : 16'h0;
	end
	// ==========================================
	// Assertions and covers
	master_clear_pin_n_free_a: assert property (master_clear_pin_n_oe_n_o)
		else $error("clear pin driven");
	master_clear_pin_n_rst_a: assert property (!master_clear_pin_n_i [*6] |-> device_reset_o)
		else $error("no reset from clear pin");
	to_pulse_a: assert property (device_reset_o && mhi > 16'd5 |=> !device_reset_o)
		else $error("time-out reset too long");
	to_early_a: assert property ($rose(device_reset_o) && mhi > 16'd5
		|-> since >= MIN_TO) else $error("time-out too soon");
	fuse_off_a: assert property (foff > 16'd5 && mhi > 16'd5 |-> !device_reset_o)
		else $error("reset with fuse off");
	sleep_go_a: assert property (sleep_instr_i && !sleeping_o && mhi > 16'd5
		|=> sleeping_o && !osc_drive_en_o || device_reset_o) else $error("no sleep");
	pin_hold_a: assert property (sleeping_o && $past(sleeping_o)
		|-> $stable(pin_out_o) && $stable(pin_oe_n_o)) else $error("pins moved");
	wake_why_a: assert property ($fell(sleeping_o)
		|-> device_reset_o || $past(device_reset_o)) else $error("wake without reset");
	sleep_c: cover property (sleep_instr_i ##1 sleeping_o);
	wake_c: cover property ($fell(sleeping_o));
	tmo_c: cover property ($rose(device_reset_o) && mhi > 16'd5);
endmodule
bind watchdog_sleep_wakeup wdt_sva #(.BASE_CYCLES(BASE_CYCLES)) sva_u (.mclk_i, .srst_i,
	.watchdog_fuse_enable_i, .master_clear_pin_n_i, .master_clear_pin_n_oe_n_o,
	.watchdog_clear_instr_i, .sleep_instr_i, .pin_out_o, .pin_oe_n_o, .osc_drive_en_o,
	.sleeping_o, .device_reset_o);
`default_nettype wire

/* tb/core_model.sv */
// Behavioural processor core: instructions, pin drive, clear pin
`default_nettype none
module core_model (
	input  wire logic  mclk_i,
	input  wire logic  sleeping_i,
	output logic       clr_o,
	output logic       slp_o,
	output logic       master_clear_pin_n_n_o,
	output logic [7:0] pin_o,
	output logic [7:0] oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet core, pins released
	initial begin
		clr_o = 1'b0;
		slp_o = 1'b0;
		master_clear_pin_n_n_o = 1'b1;
		pin_o = 8'h00;
		oe_n_o = 8'hFF;
	end
	// A halted core issues nothing while asleep
	task automatic instr(input logic sleep);
		@(posedge mclk_i);
		clr_o <= !sleep && !sleeping_i;
		slp_o <= sleep && !sleeping_i;
		@(posedge mclk_i);
		clr_o <= 1'b0;
		slp_o <= 1'b0;
	endtask
	task automatic pull_clear(input int n);
		@(posedge mclk_i);
		master_clear_pin_n_n_o <= 1'b0;
		repeat (n) @(posedge mclk_i);
		master_clear_pin_n_n_o <= 1'b1;
	endtask
	task automatic drive(input logic [7:0] v, input logic [7:0] e);
		@(posedge mclk_i);
		pin_o <= v;
		oe_n_o <= e;
	endtask
endmodule
`default_nettype wire

/* tb/watchdog_sleep_wakeup_tb_top.sv */
// Self-checking bench for the watchdog, sleep and wake-up block
`default_nettype none
module watchdog_sleep_wakeup_tb_top;
	import wdt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk_i = 1'b0;
	logic       srst_i = 1'b1;
	logic       reg_we_i = 1'b0;
	logic       reg_re_i = 1'b0;
	logic       fuse = 1'b1;
	logic [1:0] reg_addr_i = 2'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o, pin_out_o, pin_oe_n_o, cpo, cpoe;
	logic       clr, slp, master_clear_pin_n_n, osc_drive_en_o, sleeping_o, device_reset_o, irq_o;
	logic       tev = 1'b0;
	logic       tick, mc_out, mc_oe_n;
	int         n_tick = 0;
	int         n_fail = 0;
	int         check_count = 0;
	int         n_rst = 0;
	// Slow timing shortened: one watchdog tick per cycle
	watchdog_sleep_wakeup #(.BASE_CYCLES(256)) dut_u (.mclk_i, .srst_i, .reg_addr_i,
		.reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .watchdog_fuse_enable_i(fuse),
		.master_clear_pin_n_i(master_clear_pin_n_n), .master_clear_pin_n_o(mc_out),
		.master_clear_pin_n_oe_n_o(mc_oe_n),
		.watchdog_clear_instr_i(clr), .sleep_instr_i(slp), .timer_event_i(tev),
		.timer_tick_o(tick), .core_pin_out_i(cpo), .core_pin_oe_n_i(cpoe), .pin_out_o,
		.pin_oe_n_o, .osc_drive_en_o, .sleeping_o, .device_reset_o, .irq_o);
	core_model core_u (.mclk_i, .sleeping_i(sleeping_o), .clr_o(clr), .slp_o(slp),
		.master_clear_pin_n_n_o(master_clear_pin_n_n), .pin_o(cpo), .oe_n_o(cpoe));
	// Clock and reset pulse tally
	always #20 mclk_i = ~mclk_i;
	always @(posedge device_reset_o) n_rst++;
	// Divided timer ticks are one-cycle pulses with a gap between them
	always @(posedge tick) n_tick++;
	// ==========================================
	// Shared tasks
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge mclk_i);
		reg_we_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, input logic [7:0] e, input string what);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge mclk_i);
		reg_re_i <= 1'b0;
		#1;
		chk(what, e, reg_rdata_o);
	endtask
	// Bounded wait for a device reset, window in cycles
	task automatic wait_rst(input int lo, input int hi);
		int n;
		n = 0;
		while (device_reset_o !== 1'b1 && n <= hi) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk("reset delay", 8'h01, 8'(n >= lo && n <= hi));
		if (n > hi) stop_test();
	endtask
	// Four timer events at 1:2 prescale give two ticks
	task automatic timer_run();
		n_tick = 0;
		@(posedge mclk_i);
		tev <= 1'b1;
		repeat (4) @(posedge mclk_i);
		tev <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk("timer ticks", 8'h02, 8'(n_tick));
	endtask
	task automatic irq_is(input logic [7:0] e);
		@(posedge mclk_i);
		#1;
		chk("irq", e, 8'(irq_o));
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		rd(ADDR_OPTION, 8'h3F, "option");
		rd(ADDR_STATUS, 8'h18, "status");
		rd(ADDR_EVENT, 8'h00, "events");
		wr(ADDR_MASK, 8'h07);
		rd(ADDR_MASK, 8'h07, "mask");
		// Regular clears hold off the time-out, then it fires
		wr(ADDR_OPTION, 8'h00);
		timer_run();
		repeat (5) begin
			repeat (200) @(posedge mclk_i);
			core_u.instr(1'b0);
		end
		chk("early resets", 8'h00, 8'(n_rst));
		wait_rst(245, 270);
		rd(ADDR_STATUS, 8'h08, "status");
		rd(ADDR_OPTION, 8'h3F, "option");
		rd(ADDR_EVENT, 8'h01, "events");
		irq_is(8'h01);
		wr(ADDR_MASK, 8'h00);
		irq_is(8'h00);
		wr(ADDR_MASK, 8'h07);
		wr(ADDR_EVENT, 8'h07);
		irq_is(8'h00);
		// Postscale 1:2 doubles the period
		wr(ADDR_OPTION, 8'h09);
		core_u.instr(1'b0);
		wait_rst(500, 530);
		// Sleep, frozen pins, wake by time-out
		wr(ADDR_EVENT, 8'h07);
		wr(ADDR_OPTION, 8'h00);
		core_u.drive(8'hA5, 8'h0F);
		core_u.instr(1'b1);
		#1;
		chk("asleep", 8'h01, 8'(sleeping_o));
		chk("osc", 8'h00, 8'(osc_drive_en_o));
		core_u.drive(8'h5A, 8'hF0);
		repeat (3) @(posedge mclk_i);
		#1;
		chk("pins", 8'hA5, pin_out_o);
		chk("pin oe", 8'h0F, pin_oe_n_o);
		wait_rst(240, 265);
		chk("clear pin oe", 8'h01, 8'(mc_oe_n));
		chk("clear pin out", 8'h01, 8'(mc_out));
		rd(ADDR_STATUS, 8'h00, "status");
		rd(ADDR_EVENT, 8'h03, "events");
		chk("pins", 8'h5A, pin_out_o);
		// Sleep, wake by the clear pin
		wr(ADDR_EVENT, 8'h07);
		core_u.instr(1'b1);
		repeat (20) @(posedge mclk_i);
		core_u.pull_clear(8);
		#1;
		chk("awake", 8'h00, 8'(sleeping_o));
		repeat (6) @(posedge mclk_i);
		rd(ADDR_STATUS, 8'h10, "status");
		rd(ADDR_EVENT, 8'h06, "events");
		// Fuse off: no time-out at all
		@(posedge mclk_i);
		fuse <= 1'b0;
		wr(ADDR_OPTION, 8'h00);
		core_u.instr(1'b0);
		repeat (700) @(posedge mclk_i);
		chk("resets", 8'h04, 8'(n_rst));
		fuse <= 1'b1;
		core_u.instr(1'b0);
		wait_rst(240, 280);
		stop_test();
	end
endmodule
`default_nettype wire
